// ==== include/lmx_pkg.sv ====
// Shared constants and types of the LED matrix configuration register group
package lmx_pkg;

    // ********************************************************************
    // Register offsets
    // ********************************************************************
    localparam logic [7:0]  LMX_ADDR_THR_SW5_8     = 8'h05;
    localparam logic [7:0]  LMX_ADDR_THR_SW9_12    = 8'h06;
    localparam logic [7:0]  LMX_ADDR_UART_CONFIG   = 8'h07;
    localparam logic [7:0]  LMX_ADDR_TIMEOUT_STATE = 8'h08;
    localparam logic [7:0]  LMX_ADDR_FORCE_CLOSED  = 8'h09;

    // ********************************************************************
    // Widths and field positions
    // ********************************************************************
    localparam int          LMX_REG_W     = 13;
    localparam int          LMX_NUM_SW    = 12;
    localparam int          LMX_THR_W     = 3;
    localparam int          LMX_THR_PER   = 4;
    localparam int          LMX_THR_SW    = 8;
    localparam int          LMX_THR_FW    = 12;
    localparam int          LMX_CID_LSB   = 0;
    localparam int          LMX_CID_W     = 6;
    localparam int          LMX_WD_LSB    = 6;
    localparam int          LMX_WD_W      = 4;
    localparam int          LMX_UART_FW   = 10;
    localparam int          LMX_CNT_W     = 32;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [11:0] LMX_RST_THR          = 12'h000;
    localparam logic [9:0]  LMX_RST_UART         = 10'h001;
    localparam logic [11:0] LMX_RST_FALLBACK     = 12'h000;
    localparam logic [11:0] LMX_RST_FORCE_CLOSED = 12'h000;

    // Short-LED threshold codes, ascending
    typedef enum logic [2:0] {
        LMX_STH_1V4 = 3'h0,
        LMX_STH_3V6 = 3'h1,
        LMX_STH_4V0 = 3'h2,
        LMX_STH_5V5 = 3'h3,
        LMX_STH_6V0 = 3'h4,
        LMX_STH_6V6 = 3'h5,
        LMX_STH_7V2 = 3'h6,
        LMX_STH_7V7 = 3'h7
    } lmx_short_thr_t;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int unsigned LMX_CLK_HZ     = 100_000_000;
    localparam int unsigned LMX_CYC_PER_US = LMX_CLK_HZ / 1_000_000;

    typedef int unsigned lmx_wd_tab_t [1:15];

    // Watchdog durations in microseconds, codes 1..15; both top codes are 5 s
    localparam lmx_wd_tab_t LMX_WD_T_US = '{
        200, 500, 1_000, 2_000, 5_000, 10_000, 20_000, 50_000,
        100_000, 200_000, 500_000, 1_000_000, 2_000_000, 5_000_000, 5_000_000
    };

    function automatic lmx_wd_tab_t lmx_wd_cycles();
        lmx_wd_tab_t tab;
        for (int k = 1; k <= 15; k++) begin
            tab[k] = LMX_WD_T_US[k] * LMX_CYC_PER_US;
        end
        return tab;
    endfunction : lmx_wd_cycles

    // One decoded command from the UART frame decoder
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        cluster_call;
        logic [5:0]  cluster_ident;
        logic [7:0]  addr;
        logic [12:0] wdata;
    } lmx_cmd_t;

endpackage : lmx_pkg

// ==== rtl/lmx_comm_watchdog.sv ====
// Communication watchdog counter with restart and expiry pulse
`timescale 1ns/1ps
module lmx_comm_watchdog (
    input  wire logic        i_clock,    // System clock
    input  wire logic        i_reset_n,  // Async reset, active low
    input  wire logic        i_enable,   // Nonzero duration code selected
    input  wire logic        i_restart,  // Restart the count
    input  wire logic [31:0] i_limit,    // Duration in clock cycles
    output logic             o_expire    // One-cycle expiry pulse
);

    logic [31:0] count_reg;
    logic [31:0] last_count;
    logic        at_last;

    // Zero limit treated as one cycle
    assign last_count = (i_limit == 32'h0000_0000) ? 32'h0000_0000 : i_limit - 32'h0000_0001;
    assign at_last    = (count_reg >= last_count);

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_reg <= 32'h0000_0000;
        end else if (!i_enable || i_restart || at_last) begin
            count_reg <= 32'h0000_0000;
        end else begin
            count_reg <= count_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_expire <= 1'b0;
        end else begin
            o_expire <= i_enable && !i_restart && at_last;
        end
    end

endmodule : lmx_comm_watchdog

// ==== rtl/lmx_cfg_regs.sv ====
// Configuration registers, watchdog and switch override of the LED matrix
//
// Notes on behaviour
// - Threshold fields are 3 bits, codes 0-7
// - Switches 12..9 at 11:9, 8:6, 5:3, 2:0
// - Switches 7..5 at 8:6, 5:3, 2:0
// - Watchdog code bits 9:6; zero disables it
// - Codes 1-15 pick 200us up to 5s
// - Watchdog status asserts the fault pin
// - Watchdog status applies fallback state to switches
// - Fallback register: 12 bits, one means closed
// - Override bit holds its switch closed while watchdog status is clear
// - Faults evaluated only while a switch is open
// - Override field 12 bits, one per switch
`timescale 1ns/1ps
module lmx_cfg_regs #(
    parameter lmx_pkg::lmx_wd_tab_t WD_LIMIT = lmx_pkg::lmx_wd_cycles()
) (
    input  wire logic             i_clock,                 // System clock, 100 MHz
    input  wire logic             i_reset_n,               // Async reset, active low
    input  wire lmx_pkg::lmx_cmd_t i_cmd,                  // Decoded UART command
    input  wire logic             i_status_clear,          // Clear watchdog status
    input  wire logic [11:0]      i_duty_open,             // Dimming engine: 1 = open
    output logic                  o_rd_valid,              // Read answer strobe
    output logic                  o_rd_hit,                // Read hit a mapped register
    output logic [12:0]           o_rd_data,               // Read answer data
    output logic [7:0][2:0]       o_short_threshold_code,  // Switches 12..5, index 0 = 5
    output logic [5:0]            o_cluster_ident,         // Stored cluster ident
    output logic [3:0]            o_comm_timeout_select,   // Watchdog duration code
    output logic                  o_comm_timeout_flag,     // Watchdog status bit
    output logic                  o_fault_output_pin_n,    // Fault pin, active low
    output logic [11:0]           o_switch_closed,         // Bypass switch, 1 = closed
    output logic [11:0]           o_fault_eval_en          // LED fault evaluation enable
);

    // ********************************************************************
    // Storage
    // ********************************************************************
    logic [11:0] thr_sw5_8_reg;
    logic [11:0] thr_sw9_12_reg;
    logic [9:0]  uart_config_reg;
    logic [11:0] fallback_switch_state_reg;
    logic [11:0] force_closed_mask_reg;
    logic        comm_timeout_reg;

    logic        comm_timeout_next;
    logic        wr_accept;
    logic        cid_match;
    logic        wd_enable;
    logic        wd_restart;
    logic        wd_expire;
    logic [31:0] wd_limit;
    logic [3:0]  wd_code;
    logic [11:0] closed_next;
    logic [12:0] rd_data_next;
    logic        rd_hit_next;

    // ********************************************************************
    // Command qualification
    // ********************************************************************
    assign cid_match = (i_cmd.cluster_ident == uart_config_reg[lmx_pkg::LMX_CID_LSB +:
                                                               lmx_pkg::LMX_CID_W]);
    // Cluster-calls only land when the ident matches
    assign wr_accept = i_cmd.valid && i_cmd.write
                       && (!i_cmd.cluster_call || cid_match);

    // ********************************************************************
    // Register writes
    // ********************************************************************
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            thr_sw5_8_reg <= lmx_pkg::LMX_RST_THR;
        end else if (wr_accept && i_cmd.addr == lmx_pkg::LMX_ADDR_THR_SW5_8) begin
            thr_sw5_8_reg <= i_cmd.wdata[11:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            thr_sw9_12_reg <= lmx_pkg::LMX_RST_THR;
        end else if (wr_accept && i_cmd.addr == lmx_pkg::LMX_ADDR_THR_SW9_12) begin
            thr_sw9_12_reg <= i_cmd.wdata[11:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            uart_config_reg <= lmx_pkg::LMX_RST_UART;
        end else if (wr_accept && i_cmd.addr == lmx_pkg::LMX_ADDR_UART_CONFIG) begin
            uart_config_reg <= i_cmd.wdata[9:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fallback_switch_state_reg <= lmx_pkg::LMX_RST_FALLBACK;
        end else if (wr_accept && i_cmd.addr == lmx_pkg::LMX_ADDR_TIMEOUT_STATE) begin
            fallback_switch_state_reg <= i_cmd.wdata[11:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            force_closed_mask_reg <= lmx_pkg::LMX_RST_FORCE_CLOSED;
        end else if (wr_accept && i_cmd.addr == lmx_pkg::LMX_ADDR_FORCE_CLOSED) begin
            force_closed_mask_reg <= i_cmd.wdata[11:0];
        end
    end

    // ********************************************************************
    // Register reads
    // ********************************************************************
    always_comb begin
        rd_data_next = 13'h0000;
        rd_hit_next  = 1'b1;
        case (i_cmd.addr)
            lmx_pkg::LMX_ADDR_THR_SW5_8:     rd_data_next = {1'b0, thr_sw5_8_reg};
            lmx_pkg::LMX_ADDR_THR_SW9_12:    rd_data_next = {1'b0, thr_sw9_12_reg};
            lmx_pkg::LMX_ADDR_UART_CONFIG:   rd_data_next = {3'h0, uart_config_reg};
            lmx_pkg::LMX_ADDR_TIMEOUT_STATE: rd_data_next = {1'b0, fallback_switch_state_reg};
            lmx_pkg::LMX_ADDR_FORCE_CLOSED:  rd_data_next = {1'b0, force_closed_mask_reg};
            default: begin
                rd_data_next = 13'h0000;
                rd_hit_next  = 1'b0;
            end
        endcase
    end

    // Reads are addressed only; cluster-calls never answer
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_valid <= 1'b0;
            o_rd_hit   <= 1'b0;
            o_rd_data  <= 13'h0000;
        end else if (i_cmd.valid && !i_cmd.write && !i_cmd.cluster_call) begin
            o_rd_valid <= 1'b1;
            o_rd_hit   <= rd_hit_next;
            o_rd_data  <= rd_data_next;
        end else begin
            o_rd_valid <= 1'b0;
            o_rd_hit   <= 1'b0;
            o_rd_data  <= 13'h0000;
        end
    end

    // ********************************************************************
    // Communication watchdog
    // ********************************************************************
    assign wd_code   = uart_config_reg[lmx_pkg::LMX_WD_LSB +: lmx_pkg::LMX_WD_W];
    assign wd_enable = (wd_code != 4'h0);
    assign wd_limit  = wd_enable ? WD_LIMIT[wd_code] : 32'h0000_0000;
    // Any valid command kicks; a code write is itself a valid command
    assign wd_restart = i_cmd.valid
                        || (wr_accept && i_cmd.addr == lmx_pkg::LMX_ADDR_UART_CONFIG);

    lmx_comm_watchdog u_watchdog (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_enable  (wd_enable),
        .i_restart (wd_restart),
        .i_limit   (wd_limit),
        .o_expire  (wd_expire)
    );

    // Expiry wins over a clear in the same cycle
    assign comm_timeout_next = wd_expire || (comm_timeout_reg && !i_status_clear);

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            comm_timeout_reg <= 1'b0;
        end else begin
            comm_timeout_reg <= comm_timeout_next;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fault_output_pin_n <= 1'b1;
        end else begin
            o_fault_output_pin_n <= !comm_timeout_next;
        end
    end

    // ********************************************************************
    // Switch drive and fault evaluation
    // ********************************************************************
    // Fallback beats override so a lost host sees one known pattern
    genvar sw;
    generate
        for (sw = 0; sw < lmx_pkg::LMX_NUM_SW; sw++) begin : g_switch
            assign closed_next[sw] = comm_timeout_next ? fallback_switch_state_reg[sw]
                                   : (force_closed_mask_reg[sw] || !i_duty_open[sw]);
        end
    endgenerate

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_switch_closed <= 12'hfff;
        end else begin
            o_switch_closed <= closed_next;
        end
    end

    // Faults only sampled across an open switch
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fault_eval_en <= 12'h000;
        end else begin
            o_fault_eval_en <= ~closed_next;
        end
    end

    // ********************************************************************
    // Configuration outputs
    // ********************************************************************
    genvar th;
    generate
        for (th = 0; th < lmx_pkg::LMX_THR_PER; th++) begin : g_thr
            assign o_short_threshold_code[th] =
                thr_sw5_8_reg[th*lmx_pkg::LMX_THR_W +: lmx_pkg::LMX_THR_W];
            assign o_short_threshold_code[th + lmx_pkg::LMX_THR_PER] =
                thr_sw9_12_reg[th*lmx_pkg::LMX_THR_W +: lmx_pkg::LMX_THR_W];
        end
    endgenerate

    assign o_cluster_ident       = uart_config_reg[lmx_pkg::LMX_CID_LSB +: lmx_pkg::LMX_CID_W];
    assign o_comm_timeout_select = wd_code;
    assign o_comm_timeout_flag   = comm_timeout_reg;

endmodule : lmx_cfg_regs

// ==== verif/lmx_cfg_regs_assertions.sv ====
// Concurrent checks on the ports of the LED matrix configuration registers
`timescale 1ns/1ps
module lmx_cfg_chk #(
    parameter lmx_pkg::lmx_wd_tab_t WD_LIMIT = lmx_pkg::lmx_wd_cycles()
) (
    input wire logic              i_clock,                // Clock
    input wire logic              i_reset_n,              // Reset, active low
    input wire lmx_pkg::lmx_cmd_t i_cmd,                  // Command
    input wire logic              i_status_clear,         // Status clear
    input wire logic [11:0]       i_duty_open,            // Duty open request
    input wire logic              o_rd_valid,             // Read strobe
    input wire logic              o_rd_hit,               // Read hit
    input wire logic [12:0]       o_rd_data,              // Read data
    input wire logic [7:0][2:0]   o_short_threshold_code, // Thresholds
    input wire logic [5:0]        o_cluster_ident,        // Cluster ident
    input wire logic [3:0]        o_comm_timeout_select,  // Watchdog code
    input wire logic              o_comm_timeout_flag,    // Watchdog status
    input wire logic              o_fault_output_pin_n,   // Fault pin
    input wire logic [11:0]       o_switch_closed,        // Switch state
    input wire logic [11:0]       o_fault_eval_en         // Fault evaluation
);
    // ****************************************************************
    // Checks
    // ****************************************************************
    logic rd;
    logic wr_cfg;
    assign rd     = i_cmd.valid & ~i_cmd.write & ~i_cmd.cluster_call;
    assign wr_cfg = i_cmd.valid & i_cmd.write & (i_cmd.addr == lmx_pkg::LMX_ADDR_UART_CONFIG);

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    rd_answer_a: assert property (rd |=> o_rd_valid)
        else $error("read got no answer");
    rd_source_a: assert property (o_rd_valid |-> $past(rd))
        else $error("answer without read");
    thr_lo_read_a: assert property (rd && i_cmd.addr == 8'h05
        |=> o_rd_data == {1'b0, o_short_threshold_code[3:0]}) else $error("sw5-8 read");
    thr_hi_read_a: assert property (rd && i_cmd.addr == 8'h06
        |=> o_rd_data == {1'b0, o_short_threshold_code[7:4]}) else $error("sw9-12 read");
    cfg_write_a: assert property (wr_cfg && !i_cmd.cluster_call |=>
        o_cluster_ident == $past(i_cmd.wdata[5:0])
        && o_comm_timeout_select == $past(i_cmd.wdata[9:6])) else $error("config write");
    cc_drop_a: assert property (wr_cfg && i_cmd.cluster_call
        && i_cmd.cluster_ident != o_cluster_ident |=> $stable(o_cluster_ident))
        else $error("foreign cluster write taken");
    pin_follows_a: assert property (o_fault_output_pin_n != o_comm_timeout_flag)
        else $error("fault pin disagrees with status");
    eval_open_a: assert property (o_fault_eval_en == ~o_switch_closed)
        else $error("fault evaluation on closed switch");
    duty_close_a: assert property (!o_comm_timeout_flag
        |-> (o_switch_closed | $past(i_duty_open)) == 12'hfff) else $error("switch opened");
    wd_code_a: assert property ($rose(o_comm_timeout_flag)
        |-> $past(o_comm_timeout_select) != 4'h0) else $error("disabled watchdog fired");
    clear_a: assert property (i_status_clear && o_comm_timeout_flag
        |=> !o_comm_timeout_flag) else $error("status not cleared");
endmodule : lmx_cfg_chk

bind lmx_cfg_regs lmx_cfg_chk #(.WD_LIMIT(WD_LIMIT)) u_lmx_cfg_chk (.i_clock, .i_reset_n,
    .i_cmd, .i_status_clear, .i_duty_open, .o_rd_valid, .o_rd_hit, .o_rd_data,
    .o_short_threshold_code, .o_cluster_ident, .o_comm_timeout_select,
    .o_comm_timeout_flag, .o_fault_output_pin_n, .o_switch_closed, .o_fault_eval_en);

// ==== verif/lmx_host_model.sv ====
// Host microcontroller model issuing decoded register commands
`timescale 1ns/1ps
module lmx_host_model (
    input  wire logic        i_clock,    // Clock
    input  wire logic        i_rd_valid, // Read strobe
    input  wire logic        i_rd_hit,   // Read hit
    input  wire logic [12:0] i_rd_data,  // Read data
    output lmx_pkg::lmx_cmd_t o_cmd      // Command to the block
);
    initial o_cmd = '0;

    // Released fields are inverted so stale values never pass for fresh ones
    task automatic send(input logic w, input logic cc, input logic [5:0] id,
                        input logic [7:0] a, input logic [12:0] dat);
        @(posedge i_clock);
        o_cmd <= {1'b1, w, cc, id, a, dat};
        @(posedge i_clock);
        o_cmd <= {1'b0, ~o_cmd[28:0]};
        #1;
    endtask : send

    task automatic wr(input logic [7:0] a, input logic [12:0] dat);
        send(1'b1, 1'b0, 6'h00, a, dat);
    endtask : wr

    task automatic ccwr(input logic [5:0] id, input logic [7:0] a, input logic [12:0] dat);
        send(1'b1, 1'b1, id, a, dat);
    endtask : ccwr

    task automatic rd(input logic [7:0] a, output logic v, output logic h,
                      output logic [12:0] dat);
        send(1'b0, 1'b0, 6'h00, a, 13'h0000);
        v   = i_rd_valid;
        h   = i_rd_hit;
        dat = i_rd_data;
    endtask : rd

    // Called once the host judges those LEDs permanently open
    task automatic force_closed(input logic [11:0] m);
        wr(lmx_pkg::LMX_ADDR_FORCE_CLOSED, {1'b0, m});
    endtask : force_closed
endmodule : lmx_host_model

// ==== verif/tb_top.sv ====
// Self-checking testbench of the LED matrix configuration registers
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    // Shortened watchdog limits keep the run brief
    localparam lmx_pkg::lmx_wd_tab_t WD_T = '{10, 20, 30, 40, 50, 60, 70, 80, 90, 100,
                                             110, 120, 130, 140, 140};
    logic              i_clock = 1'b0;
    logic              i_reset_n = 1'b0;
    logic              i_status_clear = 1'b0;
    logic [11:0]       i_duty_open = 12'hfff;
    lmx_pkg::lmx_cmd_t i_cmd;
    logic              o_rd_valid, o_rd_hit, o_comm_timeout_flag, o_fault_output_pin_n;
    logic [12:0]       o_rd_data, d;
    logic [7:0][2:0]   o_short_threshold_code;
    logic [5:0]        o_cluster_ident;
    logic [3:0]        o_comm_timeout_select;
    logic [11:0]       o_switch_closed, o_fault_eval_en;
    logic              v, h;
    int                fail_count = 0;
    int                n_tests = 0;
    int                cycles = 0;

    always #5 i_clock = ~i_clock;

    lmx_cfg_regs #(.WD_LIMIT(WD_T)) u_lmx_cfg_regs (.i_clock, .i_reset_n, .i_cmd,
        .i_status_clear, .i_duty_open, .o_rd_valid, .o_rd_hit, .o_rd_data,
        .o_short_threshold_code, .o_cluster_ident, .o_comm_timeout_select,
        .o_comm_timeout_flag, .o_fault_output_pin_n, .o_switch_closed, .o_fault_eval_en);

    lmx_host_model u_lmx_host_model (.i_clock, .i_rd_valid(o_rd_valid),
        .i_rd_hit(o_rd_hit), .i_rd_data(o_rd_data), .o_cmd(i_cmd));

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic t_reset();
        `CHK("fault pin", 1'b1, o_fault_output_pin_n);
        for (int a = 5; a <= 9; a++) begin
            u_lmx_host_model.rd(8'(a), v, h, d);
            `CHK("reset value", (a == 7) ? 13'h0001 : 13'h0000, d);
            `CHK("read hit", 2'b11, {v, h});
        end
    endtask : t_reset

    task automatic t_thr();
        for (int c = 0; c < 8; c++) begin
            u_lmx_host_model.wr(8'h06, {1'b1, 3'(c), 3'(7 - c), 3'(c), 3'(7 - c)});
            u_lmx_host_model.wr(8'h05, {1'b1, 3'(7 - c), 3'(c), 3'(7 - c), 3'(c)});
            `CHK("sw12", 3'(c), o_short_threshold_code[7]);
            `CHK("sw9", 3'(7 - c), o_short_threshold_code[4]);
            `CHK("sw7", 3'(c), o_short_threshold_code[2]);
            `CHK("sw5", 3'(c), o_short_threshold_code[0]);
            u_lmx_host_model.rd(8'h06, v, h, d);
            `CHK("sw9-12 read", {1'b0, 3'(c), 3'(7 - c), 3'(c), 3'(7 - c)}, d);
        end
        u_lmx_host_model.rd(8'h0a, v, h, d);
        `CHK("unmapped", 15'h4000, {v, h, d});
    endtask : t_thr

    task automatic t_cluster();
        u_lmx_host_model.ccwr(6'h01, 8'h09, 13'h000f);
        u_lmx_host_model.ccwr(6'h02, 8'h09, 13'h0ff0);
        u_lmx_host_model.ccwr(6'h05, 8'h07, 13'h0005);
        u_lmx_host_model.rd(8'h09, v, h, d);
        `CHK("cc mask", 13'h000f, d);
        u_lmx_host_model.wr(8'h07, 13'h1c02);
        u_lmx_host_model.rd(8'h07, v, h, d);
        `CHK("ident", 13'h0002, d);
        `CHK("ident out", 6'h02, o_cluster_ident);
        u_lmx_host_model.ccwr(6'h02, 8'h09, 13'h10a0);
        u_lmx_host_model.rd(8'h09, v, h, d);
        `CHK("cc new ident", 13'h00a0, d);
        u_lmx_host_model.wr(8'h07, 13'h0001);
    endtask : t_cluster

    task automatic t_override();
        u_lmx_host_model.force_closed(12'h813);
        @(posedge i_clock);
        #1;
        `CHK("forced", 12'h813, o_switch_closed);
        `CHK("fault eval", 12'h7ec, o_fault_eval_en);
        @(posedge i_clock);
        i_duty_open <= 12'h00f;
        @(posedge i_clock);
        #1;
        `CHK("duty", 12'hff3, o_switch_closed);
        @(posedge i_clock);
        i_duty_open <= 12'hfff;
    endtask : t_override

    task automatic t_wd();
        int          n;
        logic [12:0] cfg;
        u_lmx_host_model.wr(8'h08, 13'h1a5a);
        for (int k = 1; k <= 15; k++) begin
            cfg = {3'h0, 4'(k), 6'h01};
            u_lmx_host_model.wr(8'h07, cfg);
            repeat (WD_T[k] / 2) @(posedge i_clock);
            // A read restarts the count; timing is measured from it
            u_lmx_host_model.rd(8'h07, v, h, d);
            `CHK("code read", cfg, d);
            `CHK("select", 4'(k), o_comm_timeout_select);
            n = 0;
            while (o_comm_timeout_flag !== 1'b1 && n < 400) begin
                @(posedge i_clock);
                #1;
                n++;
            end
            `CHK("expiry", 1'b1, (n == WD_T[k] + 1 || n == WD_T[k] + 2));
            `CHK("fault pin", 1'b0, o_fault_output_pin_n);
            `CHK("fallback", 12'ha5a, o_switch_closed);
            @(posedge i_clock);
            i_status_clear <= 1'b1;
            @(posedge i_clock);
            i_status_clear <= 1'b0;
            #1;
            `CHK("cleared", 1'b0, o_comm_timeout_flag);
            `CHK("normal", 12'h813, o_switch_closed);
        end
        u_lmx_host_model.wr(8'h07, 13'h0001);
        repeat (300) @(posedge i_clock);
        #1;
        `CHK("disabled", 1'b0, o_comm_timeout_flag);
    endtask : t_wd

    initial begin
        repeat (5) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        #1;
        t_reset();
        t_thr();
        t_cluster();
        t_override();
        t_wd();
        test_done();
    end
endmodule : tb_top
